// ===== hdl/cbd_autobaud.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - power-up without configuration starts automatic detection
// R2 - detection picks only 1M, 500k, 250k, 125k
// R3 - each segment keeps its own rate
// R4 - another node must send frames to detect
// R5 - rate seen on one segment used by both
// R6 - undetected 15 s after link up: take peer
// R7 - nothing by 15 s: first detector decides
// R8 - detection keeps waiting forever, never abandoned
// R9 - link re-establishment keeps the determined rate
// R10 - fixed preset or automatic, preset applies immediately
// R11 - detection yields full bus timing set
// R12 - clean frame needed; silent until then
module cbd_autobaud import cbd_pkg::*; #(
	parameter int FALLBACK_CLKS = FALLBACK_MS * CLK_KHZ,   // peer fallback wait
	parameter int DWELL_CLKS    = HUNT_DWELL_MS * CLK_KHZ  // listen time per candidate
) (
	input  wire logic       clk,             // system clock, 10 MHz
	input  wire logic       resetn,          // async reset, active low
	input  wire logic       can_rx,          // bus receive level
	input  wire logic       cfg_fixed,       // 1 = use preset, 0 = automatic
	input  wire logic [1:0] cfg_rate,        // preset index when fixed
	input  wire logic       link_up,         // radio link established
	input  wire logic       peer_valid,      // peer has a rate
	input  wire logic [1:0] peer_rate,       // peer rate index
	output logic      [1:0] rate,            // determined rate index
	output logic            rate_valid,      // rate determined, also told to peer
	output logic            rate_from_peer,  // rate was taken from peer
	output logic            bus_active,      // may transmit and acknowledge
	output logic      [1:0] cand_rate,       // candidate under test
	output logic      [3:0] brp,             // prescaler for the controller
	output logic      [3:0] tseg1,           // phase 1 quanta
	output logic      [2:0] tseg2,           // phase 2 quanta
	output logic      [1:0] sjw              // resync jump width
);

	localparam logic [TMR_W-1:0] FALLBACK_LAST = TMR_W'(FALLBACK_CLKS - 1);
	localparam logic [TMR_W-1:0] DWELL_LAST    = TMR_W'(DWELL_CLKS - 1);

	typedef struct packed {
		cbd_state_t       st;
		cbd_rate_t        rate;
		logic             valid;
		logic             from_peer;
		cbd_rate_t        cand;
		logic [TMR_W-1:0] dwell;
		logic [TMR_W-1:0] link_t;
		logic [TMR_W-1:0] pwr_t;
		logic             link_done;
		logic             pwr_done;
		logic             restart;
		cbd_timing_t      tim;
	} cbd_top_state_t;

	// reset state: hunting at the fastest candidate with its timing already shown
	localparam cbd_top_state_t Q_RESET = '{st: ST_HUNT, rate: RATE_1M, cand: RATE_1M,
		tim: rate_timing(RATE_1M), default: '0};

	cbd_top_state_t q;
	cbd_top_state_t next_q;
	cbd_chk_if      chk_bus ();

	// ----------------------------------------------------------------
	// frame checker on the current candidate
	// ----------------------------------------------------------------
	assign chk_bus.bit_clks  = rate_bit_clks(q.cand);
	assign chk_bus.sample_at = rate_sample_at(q.cand);
	assign chk_bus.restart   = q.restart;

	cbd_frame_check u_check (
		.clk    (clk),
		.resetn (resetn),
		.can_rx (can_rx),
		.chk    (chk_bus)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rate           = q.rate;
	assign rate_valid     = q.valid;
	assign rate_from_peer = q.from_peer;
	assign bus_active     = q.valid;      // listen only while hunting, see R12
	assign cand_rate      = q.cand;
	assign brp            = q.tim.brp;
	assign tseg1          = q.tim.tseg1;
	assign tseg2          = q.tim.tseg2;
	assign sjw            = q.tim.sjw;

	// ----------------------------------------------------------------
	// rate selection
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.restart = 1'b0;
		// power-up timer runs once
		if (!q.pwr_done) begin
			next_q.pwr_t    = q.pwr_t + TMR_W'(1);
			next_q.pwr_done = (q.pwr_t == FALLBACK_LAST);
		end
		// link timer restarts whenever the link is down
		if (!link_up) begin
			next_q.link_t    = '0;
			next_q.link_done = 1'b0;
		end else if (!q.link_done) begin
			next_q.link_t    = q.link_t + TMR_W'(1);
			next_q.link_done = (q.link_t == FALLBACK_LAST);
		end
		if (cfg_fixed) begin
			// preset wins at once, no traffic needed, see R10
			next_q.st        = ST_FIXED;
			next_q.rate      = cfg_rate;
			next_q.valid     = 1'b1;
			next_q.from_peer = 1'b0;
		end else begin
			unique case (q.st)
				ST_HUNT: begin
					if (chk_bus.frame_ok) begin
						// clean frame at candidate, see R2, see R12
						next_q.st    = ST_LOCKED;
						next_q.rate  = q.cand;
						next_q.valid = 1'b1;
					end else if (peer_valid && link_up && (q.link_done || q.pwr_done)) begin
						// adopt peer rate, see R5, see R6, see R7
						next_q.st        = ST_LOCKED;
						next_q.rate      = peer_rate;
						next_q.valid     = 1'b1;
						next_q.from_peer = 1'b1;
					end else if (chk_bus.frame_err || q.dwell == DWELL_LAST) begin
						// step through candidates forever, see R4, see R8
						next_q.cand    = q.cand + 2'h1;
						next_q.dwell   = '0;
						next_q.restart = 1'b1;
					end else begin
						next_q.dwell = q.dwell + TMR_W'(1);
					end
				end
				ST_LOCKED: begin
					// kept through link loss, peer rate ignored, see R3, see R9
					next_q.st = ST_LOCKED;
				end
				ST_FIXED: begin
					// back to automatic, restart from fastest, see R1
					next_q.st        = ST_HUNT;
					next_q.valid     = 1'b0;
					next_q.from_peer = 1'b0;
					next_q.cand      = RATE_1M;
					next_q.dwell     = '0;
					next_q.restart   = 1'b1;
				end
			endcase
		end
		// full timing of candidate or determined rate, see R11
		next_q.tim = rate_timing(next_q.st == ST_HUNT ? next_q.cand : next_q.rate);
	end

	// ----------------------------------------------------------------
	// state register; reset is hunting at the fastest rate
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			q <= Q_RESET;
		else
			q <= next_q;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_auto_default;
		@(posedge clk) disable iff (!resetn)
			(q.st != ST_LOCKED && !cfg_fixed) |=> q.st != ST_FIXED && q.valid == (q.st == ST_LOCKED);
	endproperty
	a_auto_default: assert property (p_auto_default) else $error("not hunting without preset"); // see R1

	property p_lock_cand;
		@(posedge clk) disable iff (!resetn)
			(q.st == ST_HUNT && chk_bus.frame_ok && !cfg_fixed) |=> q.valid && !q.from_peer && q.rate == $past(q.cand);
	endproperty
	a_lock_cand: assert property (p_lock_cand) else $error("detected rate differs from candidate"); // see R2

	property p_keep_own;
		@(posedge clk) disable iff (!resetn)
			(q.st == ST_LOCKED && !q.from_peer && !cfg_fixed ##1 !cfg_fixed) |-> $stable(q.rate) && !q.from_peer;
	endproperty
	a_keep_own: assert property (p_keep_own) else $error("own rate overridden"); // see R3

	property p_peer_fallback;
		@(posedge clk) disable iff (!resetn)
			(q.st == ST_HUNT && !chk_bus.frame_ok && !cfg_fixed && peer_valid && link_up && q.link_done)
			|=> q.from_peer && q.valid && q.rate == $past(peer_rate);
	endproperty
	a_peer_fallback: assert property (p_peer_fallback) else $error("peer rate not taken after link wait"); // see R6

	property p_first_wins;
		@(posedge clk) disable iff (!resetn)
			(q.st == ST_HUNT && !cfg_fixed && !q.pwr_done && !q.link_done) |=> !q.from_peer;
	endproperty
	a_first_wins: assert property (p_first_wins) else $error("peer rate taken too early"); // see R7

	property p_hunt_on;
		@(posedge clk) disable iff (!resetn)
			(q.st == ST_HUNT && !cfg_fixed && !chk_bus.frame_ok && !peer_valid && q.dwell == DWELL_LAST)
			|=> q.st == ST_HUNT && q.cand == $past(q.cand) + 2'h1 && q.restart;
	endproperty
	a_hunt_on: assert property (p_hunt_on) else $error("detection stalled or abandoned"); // see R8

	property p_link_bounce;
		@(posedge clk) disable iff (!resetn)
			(q.st == ST_LOCKED && !cfg_fixed && $fell(link_up)) |=> q.st == ST_LOCKED && $stable(q.rate) && q.valid;
	endproperty
	a_link_bounce: assert property (p_link_bounce) else $error("rate lost on link drop"); // see R9

	property p_preset;
		@(posedge clk) disable iff (!resetn)
			cfg_fixed |=> q.st == ST_FIXED && q.valid && q.rate == $past(cfg_rate) && q.tim.brp == rate_brp($past(cfg_rate));
	endproperty
	a_preset: assert property (p_preset) else $error("preset not applied next cycle"); // see R10

	property p_timing;
		@(posedge clk) disable iff (!resetn)
			q.valid |-> q.tim == rate_timing(q.rate) && brp == rate_brp(rate);
	endproperty
	a_timing: assert property (p_timing) else $error("bus timing does not match rate"); // see R11

	property p_silent;
		@(posedge clk) disable iff (!resetn) q.st == ST_HUNT |-> !bus_active && q.tim.brp == rate_brp(q.cand);
	endproperty
	a_silent: assert property (p_silent) else $error("active on bus while hunting"); // see R12

endmodule // cbd_autobaud

// ===== inc/cbd_pkg.sv
package cbd_pkg;

	// ----------------------------------------------------------------
	// clocking and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ       = 10000;     // 10 MHz system clock
	localparam int FALLBACK_MS   = 15000;     // wait before taking the peer rate
	localparam int HUNT_DWELL_MS = 20;        // time spent listening per candidate
	localparam int TMR_W         = 28;        // width of the long timers
	localparam int CNT_W         = 7;         // width of the bit-time counter

	// ----------------------------------------------------------------
	// rate candidates, 0 = fastest
	// ----------------------------------------------------------------
	typedef logic [1:0] cbd_rate_t;
	localparam cbd_rate_t RATE_1M   = 2'h0;
	localparam cbd_rate_t RATE_500K = 2'h1;
	localparam cbd_rate_t RATE_250K = 2'h2;
	localparam cbd_rate_t RATE_125K = 2'h3;

	// bit timing: same quanta layout for every preset, prescaler scales it
	localparam int TQ_PER_BIT = 10;
	localparam int TSEG1      = 7;
	localparam int TSEG2      = 2;
	localparam int SJW        = 1;

	// frame checking limits, in bits
	localparam logic [7:0] MIN_FRAME_BITS = 8'h2c;  // shortest legal frame through end of frame
	localparam logic [3:0] IDLE_BITS      = 4'hb;   // recessive bits that mark an idle bus
	localparam logic [2:0] STUFF_RUN      = 3'h6;   // equal bits that break stuffing
	localparam logic [2:0] EOF_RUN        = 3'h7;   // recessive bits that close a frame

	typedef enum logic [1:0] {
		ST_HUNT   = 2'h0,
		ST_LOCKED = 2'h1,
		ST_FIXED  = 2'h3
	} cbd_state_t;

	typedef struct packed {
		logic [3:0] brp;
		logic [3:0] tseg1;
		logic [2:0] tseg2;
		logic [1:0] sjw;
	} cbd_timing_t;

	// ----------------------------------------------------------------
	// rate arithmetic
	// ----------------------------------------------------------------
	function automatic logic [3:0] rate_brp(cbd_rate_t r);
		return 4'h1 << r;
	endfunction

	function automatic cbd_timing_t rate_timing(cbd_rate_t r);
		cbd_timing_t t;
		t.brp   = rate_brp(r);
		t.tseg1 = 4'(TSEG1);
		t.tseg2 = 3'(TSEG2);
		t.sjw   = 2'(SJW);
		return t;
	endfunction

	function automatic logic [CNT_W-1:0] rate_bit_clks(cbd_rate_t r);
		return CNT_W'(int'(rate_brp(r)) * TQ_PER_BIT);
	endfunction

	function automatic logic [CNT_W-1:0] rate_sample_at(cbd_rate_t r);
		return CNT_W'(int'(rate_brp(r)) * (1 + TSEG1) - 1);
	endfunction

endpackage

// ===== inc/cbd_chk_if.sv
`timescale 1ns/10ps
interface cbd_chk_if import cbd_pkg::*; ();
	logic [CNT_W-1:0] bit_clks;   // clocks per bit of the candidate
	logic [CNT_W-1:0] sample_at;  // sample point within the bit
	logic             restart;    // drop any frame in progress
	logic             frame_ok;   // one clean frame seen
	logic             frame_err;  // bit error at this candidate

	modport ctl (output bit_clks, sample_at, restart, input frame_ok, frame_err);
	modport chk (input bit_clks, sample_at, restart, output frame_ok, frame_err);
endinterface

// ===== hdl/cbd_frame_check.sv
`timescale 1ns/10ps
module cbd_frame_check import cbd_pkg::*; (
	input  wire logic clk,     // system clock
	input  wire logic resetn,  // async reset, active low
	input  wire logic can_rx,  // bus level, 1 = recessive
	cbd_chk_if.chk    chk      // candidate in, verdict out
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [2:0]       run;
		logic             last;
		logic [7:0]       nbits;
		logic [3:0]       idle;
		logic             in_frame;
		logic             prev_rx;
		logic             ok;
		logic             err;
	} cbd_chk_state_t;

	cbd_chk_state_t q;
	cbd_chk_state_t next_q;

	assign chk.frame_ok  = q.ok;
	assign chk.frame_err = q.err;

	// ----------------------------------------------------------------
	// bit sampling, stuffing and end-of-frame check
	// ----------------------------------------------------------------
	always_comb begin
		logic       fall;
		logic       samp;
		logic [2:0] nrun;
		fall   = q.prev_rx & ~can_rx;
		samp   = (q.cnt == chk.sample_at);
		nrun   = '0;
		next_q = q;
		next_q.ok      = 1'b0;
		next_q.err     = 1'b0;
		next_q.prev_rx = can_rx;
		next_q.cnt     = (q.cnt == chk.bit_clks - CNT_W'(1)) ? '0 : q.cnt + CNT_W'(1);
		if (chk.restart) begin
			next_q.in_frame = 1'b0;
			next_q.idle     = '0;
			next_q.cnt      = '0;
		end else if (!q.in_frame) begin
			// wait for idle bus, then hard sync on start of frame
			if (fall && q.idle == IDLE_BITS) begin
				next_q.in_frame = 1'b1;
				next_q.cnt      = '0;
				next_q.run      = '0;
				next_q.last     = 1'b1;
				next_q.nbits    = '0;
			end else if (samp) begin
				next_q.idle = !can_rx ? '0 : (q.idle == IDLE_BITS) ? q.idle : q.idle + 4'h1;
			end
		end else begin
			if (fall)
				next_q.cnt = '0;  // resync on each falling edge
			if (samp) begin
				nrun = (can_rx != q.last) ? 3'h1 : (q.run == EOF_RUN) ? q.run : q.run + 3'h1;
				next_q.run   = nrun;
				next_q.last  = can_rx;
				next_q.nbits = (&q.nbits) ? q.nbits : q.nbits + 8'h1;
				// a frame only counts when it ends cleanly, see R12
				if (!can_rx && nrun == STUFF_RUN)
					next_q.err = 1'b1;
				else if (can_rx && nrun == STUFF_RUN && next_q.nbits < MIN_FRAME_BITS)
					next_q.err = 1'b1;
				else if (can_rx && nrun == EOF_RUN)
					next_q.ok = 1'b1;
				if (next_q.ok || next_q.err) begin
					next_q.in_frame = 1'b0;
					next_q.idle     = '0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			q <= '0;
		else
			q <= next_q;
	end

	property p_verdict_single;
		@(posedge clk) disable iff (!resetn) q.ok |-> !q.err && !q.in_frame && $past(q.in_frame);
	endproperty
	a_verdict_single: assert property (p_verdict_single) else $error("frame verdict without a frame"); // see R12

endmodule // cbd_frame_check

// ===== dv/cbd_can_node.sv
`timescale 1ns/10ps
module cbd_can_node import cbd_pkg::*; (
	input  wire logic       clk,     // system clock
	input  wire logic       en,      // keep sending frames
	input  wire logic [1:0] rate,    // rate index of the traffic
	output logic            can_rx,  // bus level, 1 = recessive
	output logic            busy     // frame or gap in progress
);
	// ----------------------------------------------------------------
	// one bit on the wire
	// ----------------------------------------------------------------
	task automatic send_bit(logic b);
		repeat (10 << rate) @(posedge clk) can_rx <= b;
	endtask

	// gap, then a frame whose runs of three break every faster candidate
	initial begin
		can_rx = 1'b1;
		busy   = 1'b0;
		forever begin
			@(posedge clk);
			if (en) begin
				busy <= 1'b1;
				for (int k = 0; k < 14; k++) send_bit(1'b1);
				for (int k = 0; k < 42; k++) send_bit(logic'((k / 3) % 2));
				for (int k = 0; k < 8; k++) send_bit(1'b1);
				busy <= 1'b0;
			end
		end
	end
endmodule // cbd_can_node

// ===== dv/testbench.sv
`timescale 1ns/10ps
module testbench import cbd_pkg::*; ;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk, resetn, can_rx, cfg_fixed, link_up, peer_valid;
	logic [1:0]  cfg_rate, peer_rate, rate, cand_rate, sjw, node_rate;
	logic        rate_valid, rate_from_peer, bus_active, node_en, node_busy;
	logic [3:0]  brp, tseg1;
	logic [2:0]  tseg2;
	logic [31:0] seed;
	int          n_fail, checks, cycles;
	int          exp_q[$];

	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	cbd_autobaud #(.FALLBACK_CLKS(200), .DWELL_CLKS(20000)) cbd_autobaud_i (
		.clk(clk), .resetn(resetn), .can_rx(can_rx), .cfg_fixed(cfg_fixed),
		.cfg_rate(cfg_rate), .link_up(link_up), .peer_valid(peer_valid),
		.peer_rate(peer_rate), .rate(rate), .rate_valid(rate_valid),
		.rate_from_peer(rate_from_peer), .bus_active(bus_active),
		.cand_rate(cand_rate), .brp(brp), .tseg1(tseg1), .tseg2(tseg2), .sjw(sjw));

	cbd_can_node cbd_can_node_i (.clk(clk), .en(node_en), .rate(node_rate),
		.can_rx(can_rx), .busy(node_busy));

	// clock, 100 ns period
	always #50 clk = ~clk;

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrap_up();
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp(string name, logic [3:0] exp, logic [3:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// compare every output but cand_rate against the next expected locked rate
	task automatic chk_lock(logic from_peer);
		int r;
		r = exp_q.pop_front();
		cmp("rate", 4'(r), {2'h0, rate});
		cmp("rate_valid", 4'h1, {3'h0, rate_valid});
		cmp("rate_from_peer", {3'h0, from_peer}, {3'h0, rate_from_peer});
		cmp("bus_active", 4'h1, {3'h0, bus_active});
		cmp("brp", 4'(1 << r), brp);
		cmp("tseg1", 4'h7, tseg1);
		cmp("tseg2", 4'h2, {1'h0, tseg2});
		cmp("sjw", 4'h1, {2'h0, sjw});
	endtask

	task automatic chk_idle();
		cmp("rate_valid", 4'h0, {3'h0, rate_valid});
		cmp("bus_active", 4'h0, {3'h0, bus_active});
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_valid(int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if (rate_valid === 1'b1) break;
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		cfg_fixed = 1'b0;
		cfg_rate = 2'h0;
		link_up = 1'b1;
		peer_valid = 1'b1;
		peer_rate = 2'h2;
		node_en = 1'b0;
		node_rate = 2'h0;
		seed = 32'h18be86b8;
		n_fail = 0;
		checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		// unconfigured start hunts and keeps quiet while the peer is ignored
		tick(150);
		chk_idle();
		cmp("brp", 4'h1, brp);
		// peer rate taken once the wait has run out
		exp_q.push_back(2);
		wait_valid(100);
		chk_lock(1'b1);
		// link drop and peer changes leave the rate alone
		@(posedge clk) link_up <= 1'b0;
		seed = lfsr_next(seed);
		tick(10);
		@(posedge clk) peer_rate <= seed[1:0];
		link_up <= 1'b1;
		exp_q.push_back(2);
		tick(250);
		chk_lock(1'b1);
		// presets, every index then random ones
		for (int i = 0; i < 8; i++) begin
			seed = lfsr_next(seed);
			@(posedge clk) cfg_fixed <= 1'b1;
			cfg_rate <= (i < 4) ? 2'(i) : seed[1:0];
			exp_q.push_back((i < 4) ? i : int'(seed[1:0]));
			tick(2);
			chk_lock(1'b0);
		end
		// back to automatic: hunting restarts at the fastest candidate
		@(posedge clk) cfg_fixed <= 1'b0;
		peer_valid <= 1'b0;
		tick(2);
		chk_idle();
		cmp("cand_rate", 4'h0, {2'h0, cand_rate});
		// long silence does not end the hunt
		tick(25000);
		chk_idle();
		// detection of each rate from local traffic, slowest first
		for (int r = 3; r >= 0; r--) begin
			@(posedge clk) node_en <= 1'b1;
			node_rate <= 2'(r);
			exp_q.push_back(r);
			tick(1);
			chk_idle();
			wait_valid(40000);
			chk_lock(1'b0);
			cmp("brp", 4'(1 << r), brp);
			@(posedge clk) node_en <= 1'b0;
			for (int i = 0; i < 6000; i++) begin
				tick(1);
				if (node_busy === 1'b0) break;
			end
			@(posedge clk) cfg_fixed <= 1'b1;
			@(posedge clk) cfg_fixed <= 1'b0;
			tick(2);
			chk_idle();
		end
		// power-up wait long over: peer rate taken although the link is fresh
		seed = lfsr_next(seed);
		@(posedge clk) link_up <= 1'b0;
		@(posedge clk) link_up <= 1'b1;
		peer_valid <= 1'b1;
		peer_rate <= seed[1:0];
		exp_q.push_back(int'(seed[1:0]));
		tick(3);
		chk_lock(1'b1);
		wrap_up();
	end
endmodule // testbench
